/* dv/cpo_port_output_and_misc_ops_tb.sv */
// Self-checking testbench for the port-output and misc execution block.
`timescale 1ns/1ps

module cpo_port_output_and_misc_ops_tb;
    import cpo_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    cpo_instr_t  instrIn = '0;
    logic [3:0]  accIn   = 4'h0;
    logic [3:0]  dataPtr = 4'h0;
    logic [3:0]  ramNibble;
    logic [1:0]  bankSel;
    cpo_ports_t  portOut;
    cpo_acc_wr_t accWr;
    logic        pcAdvance, skipNext, carryWe, instrHit;
    int          bad_count = 0;
    int          compares  = 0;
    // Reference state, kept as plain integers.
    int          eBank, eK, eP0, eP1, eP2, eP3, eWe, eAcc, ePc;
    logic [9:0]  codes [10] = '{10'h000, 10'h019, 10'h048, 10'h049, 10'h04A, 10'h04B,
                                10'h21F, 10'h220, 10'h221, 10'h222};

    cpo_exec u_cpo_exec (.clk_sys(clk_sys), .rst(rst), .instrIn(instrIn), .accIn(accIn),
        .ramNibble(ramNibble), .bankSel(bankSel), .portOut(portOut), .accWr(accWr),
        .pcAdvance(pcAdvance), .skipNext(skipNext), .carryWe(carryWe), .instrHit(instrHit));

    cpo_ram_model u_cpo_ram_model (.dataPtr(dataPtr), .ramNibble(ramNibble));

    // ==============================================================
    // Clock, 25 ns period.
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic bit isOurs(logic [9:0] w);
        return w == 10'h000 || w == 10'h019 || w[9:2] == 8'h12 || w == 10'h21F || w[9:2] == 8'h88;
    endfunction

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ==============================================================
    // Advance the reference by one taken edge; valid=0 or foreign words change nothing.
    task automatic step_model();
        logic [9:0] w;
        w = instrIn.word;
        eWe = 0;
        ePc = 0;
        if (rst) begin
            {eBank, eK, eP0, eP1, eP2, eP3, eAcc} = '0;
        end else if (instrIn.valid === 1'b1 && isOurs(w)) begin
            ePc = 1;
            if (w[9:2] == 8'h12) eBank = w[1:0];
            if (w == 10'h21F) eK = accIn[0];
            if (w == 10'h220) eP0 = accIn;
            if (w == 10'h221) eP1 = accIn;
            if (w == 10'h222) eP2 = accIn[1:0];
            if (w == 10'h223) eP3 = accIn[1:0];
            if (w == 10'h019) begin
                eWe  = 1;
                eAcc = accIn | ramNibble;
            end
        end
    endtask

    // One bus cycle: drive at the edge, check settled outputs at the falling edge.
    task automatic cycle(input logic r, input logic v, input logic [9:0] w,
                         input logic [3:0] a, input logic [3:0] p);
        logic [23:0] got, exp;
        @(posedge clk_sys);
        rst     <= r;
        instrIn <= '{valid: v, word: w};
        accIn   <= a;
        dataPtr <= p;
        @(negedge clk_sys);
        got = {bankSel, portOut, accWr, pcAdvance, skipNext, carryWe, instrHit};
        exp = {2'(eBank), 1'(eK), 4'(eP0), 4'(eP1), 2'(eP2), 2'(eP3), 1'(eWe), 4'(eAcc),
               1'(ePc), 2'b00, 1'(v && isOurs(w))};
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
        step_model();
    endtask

    // ==============================================================
    // Watchdog sized far above the roughly 640 cycles the tests take.
    initial begin
        #75000;
        bad_count++;
        close_out();
    end

    initial begin
        logic [9:0] w;
        {eBank, eK, eP0, eP1, eP2, eP3, eWe, eAcc, ePc} = '0;
        void'($urandom(32'h4059));
        // Reset is seen high at the first two edges only.
        cycle(1'b1, 1'b0, 10'h000, 4'h0, 4'h0);
        cycle(1'b0, 1'b0, 10'h000, 4'h0, 4'h0);
        // Every code back to back, port three appended last.
        for (int i = 0; i < 11; i++) begin
            w = (i < 10) ? codes[i] : 10'h223;
            cycle(1'b0, 1'b1, w, 4'($urandom), 4'($urandom));
        end
        cycle(1'b0, 1'b0, 10'h000, 4'h0, 4'h0);
        $display("Test directed codes done");
        // Random mix of our codes, foreign words and idle cycles.
        for (int i = 0; i < 600; i++) begin
            w = ($urandom % 12 < 10) ? codes[$urandom % 10] : 10'($urandom);
            if ($urandom % 8 == 0) w = 10'h223;
            cycle(1'b0, 1'($urandom % 4 != 0), w, 4'($urandom), 4'($urandom));
        end
        $display("Test random stream done");
        // Reset in mid-run while a live word is presented, then resume.
        cycle(1'b1, 1'b1, 10'h220, 4'hF, 4'h0);
        cycle(1'b1, 1'b1, 10'h04B, 4'hF, 4'h0);
        for (int i = 0; i < 20; i++) begin
            cycle(1'b0, 1'b1, codes[$urandom % 10], 4'($urandom), 4'($urandom));
        end
        cycle(1'b0, 1'b0, 10'h000, 4'h0, 4'h0);
        $display("Test mid-run reset done");
        close_out();
    end
endmodule // cpo_port_output_and_misc_ops_tb

/* dv/cpo_ram_model.sv */
// Behavioural data RAM that answers the nibble addressed by the data pointer.
`timescale 1ns/1ps

module cpo_ram_model (
    input  wire logic [3:0] dataPtr,
    output logic      [3:0] ramNibble
);
    logic [3:0] memArr [16];

    // ==============================================================
    // Fill with a scrambled pattern so that neighbouring addresses differ.
    initial begin
        for (int i = 0; i < 16; i++) begin
            memArr[i] = 4'((i * 7) ^ 4'hA);
        end
    end

    // The read is combinational, as the core sees the pointed nibble with the instruction.
    assign ramNibble = memArr[dataPtr];
endmodule // cpo_ram_model

/* hdl/cpo_exec.sv */
// Execution logic for bank load, no-operation, port output and OR-with-memory instructions.
//
// Behaviour
// - Word 00010010zz loads the two-bit immediate zz into the bank-select register in one cycle.
// - The all-zero word only advances the program counter by one and changes nothing else.
// - Word 1000011111 drives accumulator bit 0 onto the single-bit port, carry untouched.
// - Word 1000100000 copies all four accumulator bits to port zero, carry untouched.
// - Word 1000100001 copies all four accumulator bits to port one, carry untouched.
// - Word 1000100010 copies accumulator bits 1 and 0 to the two bits of port two.
// - Word 1000100011 copies accumulator bits 1 and 0 to port three, carry untouched.
// - Word 0000011001 writes accumulator OR the data-pointer RAM nibble back to the accumulator.
// - None of these words skips the next one; each advances the program counter by one.
`timescale 1ns/1ps
`include "cpo_regs.svh"

module cpo_exec
    import cpo_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  cpo_instr_t       instrIn,
    input  wire logic [3:0]  accIn,
    input  wire logic [3:0]  ramNibble,
    output logic      [1:0]  bankSel,
    output cpo_ports_t       portOut,
    output cpo_acc_wr_t      accWr,
    output logic             pcAdvance,
    output logic             skipNext,
    output logic             carryWe,
    output logic             instrHit
);

    // ==============================================================
    // Decode.
    // Each class is a full-word compare except the bank load, whose low two bits are data.
    logic       isBank;
    logic       isNoOp;
    logic       isBit;
    logic       isPortZero;
    logic       isPortOne;
    logic       isPortTwo;
    logic       isPortThree;
    logic       isOrMem;
    logic       anyHit;
    logic [1:0] bankImm;

    assign isBank      = instrIn.valid &&
                         ((instrIn.word & `CPO_OP_BANK_MASK) == `CPO_OP_BANK_BASE);
    assign bankImm     = instrIn.word[`CPO_IMM_MSB:`CPO_IMM_LSB];
    assign isNoOp      = instrIn.valid && (instrIn.word == `CPO_OP_NO_OPERATION);
    assign isBit       = instrIn.valid && (instrIn.word == `CPO_OP_BIT_PORT);
    assign isPortZero  = instrIn.valid && (instrIn.word == `CPO_OP_PORT_ZERO);
    assign isPortOne   = instrIn.valid && (instrIn.word == `CPO_OP_PORT_ONE);
    assign isPortTwo   = instrIn.valid && (instrIn.word == `CPO_OP_PORT_TWO);
    assign isPortThree = instrIn.valid && (instrIn.word == `CPO_OP_PORT_THREE);
    assign isOrMem     = instrIn.valid && (instrIn.word == `CPO_OP_OR_MEM);
    assign anyHit      = isBank | isNoOp | isBit | isPortZero | isPortOne |
                         isPortTwo | isPortThree | isOrMem;

    // The hit flag is a handshake toward the core, so it stays combinational.
    assign instrHit = anyHit;

    // ==============================================================
    // Bank-select register and output port latches.
    cpo_out_latch #(.WIDTH(2)) u_bank (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (isBank),
        .d       (bankImm),
        .q       (bankSel)
    );

    cpo_out_latch #(.WIDTH(1)) u_bit (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (isBit),
        .d       (accIn[`CPO_BIT_POS]),
        .q       (portOut.bitK)
    );

    cpo_out_latch #(.WIDTH(4)) u_port0 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (isPortZero),
        .d       (accIn),
        .q       (portOut.portZero)
    );

    cpo_out_latch #(.WIDTH(4)) u_port1 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (isPortOne),
        .d       (accIn),
        .q       (portOut.portOne)
    );

    // Only the low two accumulator bits reach the narrow ports; the upper two are dropped.
    cpo_out_latch #(.WIDTH(2)) u_port2 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (isPortTwo),
        .d       (accIn[`CPO_NARROW_MSB:`CPO_NARROW_LSB]),
        .q       (portOut.portTwo)
    );

    cpo_out_latch #(.WIDTH(2)) u_port3 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (isPortThree),
        .d       (accIn[`CPO_NARROW_MSB:`CPO_NARROW_LSB]),
        .q       (portOut.portThree)
    );

    // ==============================================================
    // Accumulator write-back and program-counter step.
    logic       accWe_ff;
    logic [3:0] accData_ff;
    logic       pcAdv_ff;
    logic       nxt_accWe;
    logic [3:0] nxt_accData;
    logic       nxt_pcAdv;

    // Only the OR word touches the accumulator; the data is held between writes.
    assign nxt_accWe   = isOrMem;
    assign nxt_accData = isOrMem ? (accIn | ramNibble) : accData_ff;
    // Every word of this group is one word long, so the counter always steps by one.
    assign nxt_pcAdv   = anyHit;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            accWe_ff   <= 1'b0;
            accData_ff <= `CPO_ACC_RST;
            pcAdv_ff   <= 1'b0;
        end else begin
            accWe_ff   <= nxt_accWe;
            accData_ff <= nxt_accData;
            pcAdv_ff   <= nxt_pcAdv;
        end
    end

    assign accWr.we   = accWe_ff;
    assign accWr.data = accData_ff;
    assign pcAdvance  = pcAdv_ff;

    // No word here skips its successor or writes the carry flag.
    assign skipNext = 1'b0;
    assign carryWe  = 1'b0;

    // ==============================================================
    // Assertions.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A decoded word of this group followed by its one-step retirement.
    sequence seq_decoded;
        anyHit;
    endsequence

    sequence seq_retired;
        pcAdvance && !skipNext;
    endsequence

    a_bank_load: assert property (isBank |=> bankSel == $past(bankImm))
        else $error("Bank select did not take the immediate.");

    // Checked against the raw word, not the decode wire, so a wrong slice is caught.
    a_bank_field: assert property (isBank |=>
                                   bankSel == $past(instrIn.word[1:0]) && $stable(portOut))
        else $error("Bank immediate not taken from the low bits.");

    a_idle_quiet: assert property (isNoOp |=> pcAdvance && !accWr.we &&
                                  $stable(bankSel) && $stable(portOut))
        else $error("No-operation changed state.");

    a_bit_port: assert property (isBit |=> portOut.bitK == $past(accIn[0]) &&
                                 !carryWe)
        else $error("Single-bit port not loaded from accumulator bit 0.");

    a_port_zero: assert property (isPortZero |=> portOut.portZero == $past(accIn))
        else $error("Port zero not loaded from accumulator.");

    a_port_one: assert property (isPortOne |=> portOut.portOne == $past(accIn) &&
                                 $stable(portOut.portZero))
        else $error("Port one not loaded from accumulator.");

    a_port_two: assert property (isPortTwo |=> portOut.portTwo == $past(accIn[1:0]))
        else $error("Port two not loaded from low accumulator bits.");

    a_port_three: assert property (isPortThree |=>
                                   portOut.portThree == $past(accIn[1:0]) &&
                                   $stable(portOut.portTwo))
        else $error("Port three not loaded from low accumulator bits.");

    a_or_result: assert property (isOrMem |=> accWr.we &&
                                  accWr.data == ($past(accIn) | $past(ramNibble)))
        else $error("OR result written back wrongly.");

    a_or_only: assert property (accWr.we |-> $past(isOrMem))
        else $error("Accumulator written by a word other than OR.");

    a_no_skip: assert property (seq_decoded |=> seq_retired)
        else $error("Word did not retire with a single step.");

    a_step_cause: assert property (pcAdvance |-> $past(anyHit))
        else $error("Counter stepped without a decoded word.");

    a_ports_hold: assert property (!(isBit | isPortZero | isPortOne |
                                     isPortTwo | isPortThree) |=> $stable(portOut))
        else $error("Port latch changed without an output word.");

endmodule // cpo_exec

/* hdl/cpo_out_latch.sv */
// Loadable holding latch used for the bank register and every output port.
`timescale 1ns/1ps

module cpo_out_latch #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    // ==============================================================
    // Holding register.
    logic [WIDTH-1:0] hold_ff;
    logic [WIDTH-1:0] nxt_hold;

    // The value persists until the next load, so pins never glitch between writes.
    assign nxt_hold = load ? d : hold_ff;

    // Synchronous reset clears to zero, a quiet level on every port.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_ff <= {WIDTH{1'b0}};
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    assign q = hold_ff;

endmodule // cpo_out_latch

/* hdl/cpo_pkg.sv */
// Types shared by the port-output and misc execution block.
package cpo_pkg;

    // ==============================================================
    // Instruction word as handed over by the fetch unit.
    typedef struct packed {
        logic       valid;
        logic [9:0] word;
    } cpo_instr_t;

    // ==============================================================
    // Output port latches as seen by the pin drivers.
    typedef struct packed {
        logic       bitK;
        logic [3:0] portZero;
        logic [3:0] portOne;
        logic [1:0] portTwo;
        logic [1:0] portThree;
    } cpo_ports_t;

    // ==============================================================
    // Accumulator write-back request.
    typedef struct packed {
        logic       we;
        logic [3:0] data;
    } cpo_acc_wr_t;

endpackage

/* hdl/cpo_regs.svh */
// Opcode, mask and reset-value constants for the port-output and misc execution block.
`ifndef CPO_REGS_SVH
`define CPO_REGS_SVH

// ==============================================================
// Instruction encodings, 10-bit words.
`define CPO_OP_NO_OPERATION 10'h000
`define CPO_OP_OR_MEM     10'h019
`define CPO_OP_BANK_BASE  10'h048
`define CPO_OP_BANK_MASK  10'h3FC
`define CPO_OP_BIT_PORT   10'h21F
`define CPO_OP_PORT_ZERO  10'h220
`define CPO_OP_PORT_ONE   10'h221
`define CPO_OP_PORT_TWO   10'h222
`define CPO_OP_PORT_THREE 10'h223

// ==============================================================
// Field positions and reset values.
`define CPO_IMM_MSB       1
`define CPO_IMM_LSB       0
`define CPO_NARROW_MSB    1
`define CPO_NARROW_LSB    0
`define CPO_BIT_POS       0
`define CPO_BANK_RST      2'h0
`define CPO_PORT4_RST     4'h0
`define CPO_PORT2_RST     2'h0
`define CPO_BIT_RST       1'h0
`define CPO_ACC_RST       4'h0

`endif
